// >>> src/two_wire_master_receiver.v
// Two-wire master receiver with an AXI4-Lite register slave.
// What this block does
// - START waits until the bus is free.
// - After START, set flag, status 0x08.
// - Address direction bit picks transmit or receive.
// - After address acknowledge: flag, status 0x38/0x40/0x48.
// - Received byte readable in data when flag sets.
// - Repeated START reports 0x10, keeps bus ownership.
// - In 0x10, address direction selects mode again.
// - Lost arbitration: release bus or restart when free.
// - In 0x40, receive byte, acknowledge per enable.
// - In 0x48, repeated START, STOP, or both.
// - Stop request clears itself after STOP sent.
// - In 0x50, next byte acknowledged per enable.
// - In 0x58, repeated START, STOP, or both.
// - Data write with flag low sets collision.
`timescale 1ns/1ns
`default_nettype none
`include "two_wire_map.vh"

module two_wire_master_receiver (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // AXI4-Lite write address
  input wire i_awvalid,
  output reg o_awready,
  input wire [4:0] i_awaddr,
  input wire [2:0] i_awprot,
  // AXI4-Lite write data
  input wire i_wvalid,
  output reg o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  // AXI4-Lite write response
  output reg o_bvalid,
  input wire i_bready,
  output reg [1:0] o_bresp,
  // AXI4-Lite read address
  input wire i_arvalid,
  output reg o_arready,
  input wire [4:0] i_araddr,
  input wire [2:0] i_arprot,
  // AXI4-Lite read data
  output reg o_rvalid,
  input wire i_rready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  // Two-wire bus, output enables low while pulling low
  input wire i_scl,
  output reg o_scl,
  output reg o_scl_oe_n,
  input wire i_sda,
  output reg o_sda,
  output reg o_sda_oe_n
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_WAIT_FREE = 3'd1;
  localparam [2:0] S_START = 3'd2;
  localparam [2:0] S_BIT = 3'd3;
  localparam [2:0] S_STOP = 3'd4;
  localparam [1:0] K_ADDR = 2'd0;
  localparam [1:0] K_TX = 2'd1;
  localparam [1:0] K_RX = 2'd2;
  localparam [31:0] QUARTER_INT = `QUARTER_CYCLES;
  localparam [15:0] RATE_RST = QUARTER_INT[15:0];

  // ****************************************
  // Address decode
  // ****************************************
  function hit;
    input [4:0] addr;
    input [4:0] off;
    begin
      hit = (addr[4:2] == off[4:2]);
    end
  endfunction

  reg [4:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg flag_q;
  reg ack_en_q;
  reg start_q;
  reg stop_q;
  reg wc_q;
  reg en_q;
  reg ie_q;
  reg [7:0] status_q;
  reg [7:0] data_q;
  reg [15:0] rate_q;
  reg [15:0] qcnt_q;
  reg [2:0] state_q;
  reg [1:0] ph_q;
  reg [3:0] bit_q;
  reg [8:0] tx_q;
  reg [8:0] rx_q;
  reg [1:0] kind_q;
  reg owns_q;
  reg mrx_q;
  reg scl_drv_q;
  reg sda_drv_q;

  wire scl_s;
  wire sda_s;
  wire busy;

  line_monitor u_line_monitor (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_scl_s(scl_s),
    .o_sda_s(sda_s),
    .o_busy(busy)
  );

  // ****************************************
  // Write strobes and quarter-bit timing
  // ****************************************
  wire wr_go = !o_awready && !o_wready && !o_bvalid;
  wire wr_hit = hit(awaddr_q, `OFF_CONTROL) || hit(awaddr_q, `OFF_STATUS) ||
                hit(awaddr_q, `OFF_DATA) || hit(awaddr_q, `OFF_RATE) ||
                hit(awaddr_q, `OFF_MODE);
  wire ctl_wr = wr_go && wstrb_q[0] && hit(awaddr_q, `OFF_CONTROL);
  wire data_wr = wr_go && wstrb_q[0] && hit(awaddr_q, `OFF_DATA);
  wire go = ctl_wr && wdata_q[`CTL_FLAG] && wdata_q[`CTL_EN] && en_q;
  wire stall = (state_q == S_START || state_q == S_BIT || state_q == S_STOP) &&
               ph_q == 2'd2 && !scl_s;
  wire step = (qcnt_q == 16'h0000) && !stall;
  wire arb = tx_q[8] && !sda_s && ((kind_q != K_RX) ? (bit_q != 4'd8) : (bit_q == 4'd8));
  wire nack_in = rx_q[0];

  // ****************************************
  // Read data multiplexer
  // ****************************************
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    if (hit(i_araddr, `OFF_CONTROL)) begin
      rd_val[`CTL_FLAG] = flag_q;
      rd_val[`CTL_ACK] = ack_en_q;
      rd_val[`CTL_START] = start_q;
      rd_val[`CTL_STOP] = stop_q;
      rd_val[`CTL_WC] = wc_q;
      rd_val[`CTL_EN] = en_q;
      rd_val[`CTL_IE] = ie_q;
    end else if (hit(i_araddr, `OFF_STATUS)) begin
      rd_val[7:0] = {status_q[7:3], 3'b000};
    end else if (hit(i_araddr, `OFF_DATA)) begin
      rd_val[7:0] = data_q;
    end else if (hit(i_araddr, `OFF_RATE)) begin
      rd_val[15:0] = rate_q;
    end else if (hit(i_araddr, `OFF_MODE)) begin
      rd_val[2:0] = {owns_q, mrx_q, busy};
    end
  end

  wire rd_hit = hit(i_araddr, `OFF_CONTROL) || hit(i_araddr, `OFF_STATUS) ||
                hit(i_araddr, `OFF_DATA) || hit(i_araddr, `OFF_RATE) ||
                hit(i_araddr, `OFF_MODE);

  // ****************************************
  // Bus slave, registers and bus engine
  // ****************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `RESP_OKAY;
      o_scl <= 1'b0;
      o_sda <= 1'b0;
      o_scl_oe_n <= 1'b1;
      o_sda_oe_n <= 1'b1;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      flag_q <= 1'b0;
      ack_en_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      wc_q <= 1'b0;
      en_q <= 1'b0;
      ie_q <= 1'b0;
      status_q <= `STATUS_RST;
      data_q <= `DATA_RST;
      rate_q <= RATE_RST;
      qcnt_q <= 16'h0000;
      state_q <= S_IDLE;
      ph_q <= 2'd0;
      bit_q <= 4'h0;
      tx_q <= 9'h1ff;
      rx_q <= 9'h1ff;
      kind_q <= K_ADDR;
      owns_q <= 1'b0;
      mrx_q <= 1'b0;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end else begin
      // Write channels are taken in either order, answered once both are held.
      if (i_awvalid && o_awready) begin
        awaddr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
      // Read channel answers one cycle after the address is taken.
      if (i_arvalid && o_arready) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_val;
        o_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
      // Software register writes.
      if (ctl_wr) begin
        if (wdata_q[`CTL_FLAG]) begin
          flag_q <= 1'b0;
        end
        ack_en_q <= wdata_q[`CTL_ACK];
        start_q <= wdata_q[`CTL_START];
        stop_q <= wdata_q[`CTL_STOP];
        en_q <= wdata_q[`CTL_EN];
        ie_q <= wdata_q[`CTL_IE];
      end
      if (data_wr) begin
        if (flag_q) begin
          data_q <= wdata_q[7:0];
          wc_q <= 1'b0;
        end else begin
          wc_q <= 1'b1;
        end
      end
      if (wr_go && hit(awaddr_q, `OFF_RATE)) begin
        if (wstrb_q[0]) begin
          rate_q[7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          rate_q[15:8] <= wdata_q[15:8];
        end
      end
      // Quarter-bit divider, held while a slave stretches the clock.
      if (qcnt_q == 16'h0000) begin
        if (!stall) begin
          qcnt_q <= (rate_q == 16'h0000) ? 16'h0000 : rate_q - 16'h0001;
        end
      end else begin
        qcnt_q <= qcnt_q - 16'h0001;
      end
      o_scl_oe_n <= ~scl_drv_q;
      o_sda_oe_n <= ~sda_drv_q;
      // Bus engine.
      case (state_q)
        S_IDLE: begin
          // The clock stays pulled low here while the flag is set, except after lost arbitration (0x38), which releases both lines.
          if (go) begin
            ph_q <= 2'd0;
            if (wdata_q[`CTL_STOP] && owns_q) begin
              state_q <= S_STOP;
            end else if (wdata_q[`CTL_START]) begin
              stop_q <= 1'b0;
              state_q <= owns_q ? S_START : S_WAIT_FREE;
            end else if (wdata_q[`CTL_STOP]) begin
              stop_q <= 1'b0;
            end else if (status_q == `ST_START || status_q == `ST_RSTART ||
                         status_q == `ST_AW_ACK || status_q == `ST_AW_NACK ||
                         status_q == `ST_DT_ACK || status_q == `ST_DT_NACK) begin
              tx_q <= {data_q, 1'b1};
              kind_q <= (status_q == `ST_START || status_q == `ST_RSTART) ? K_ADDR : K_TX;
              bit_q <= 4'h0;
              state_q <= S_BIT;
            end else if (status_q == `ST_AR_ACK || status_q == `ST_DR_ACK) begin
              tx_q <= {8'hff, ~wdata_q[`CTL_ACK]};
              kind_q <= K_RX;
              bit_q <= 4'h0;
              state_q <= S_BIT;
            end else if (status_q == `ST_ARB_LOST) begin
              owns_q <= 1'b0;
              mrx_q <= 1'b0;
              scl_drv_q <= 1'b0;
              sda_drv_q <= 1'b0;
              status_q <= `ST_NONE;
            end
          end
        end
        S_WAIT_FREE: begin
          if (!busy) begin
            state_q <= S_START;
            ph_q <= 2'd0;
          end
        end
        S_START: begin
          if (step) begin
            ph_q <= ph_q + 2'd1;
            case (ph_q)
              2'd0: sda_drv_q <= 1'b0;
              2'd1: scl_drv_q <= 1'b0;
              2'd2: sda_drv_q <= 1'b1;
              default: begin
                scl_drv_q <= 1'b1;
                flag_q <= 1'b1;
                status_q <= owns_q ? `ST_RSTART : `ST_START;
                owns_q <= 1'b1;
                state_q <= S_IDLE;
              end
            endcase
          end
        end
        S_BIT: begin
          if (step) begin
            ph_q <= ph_q + 2'd1;
            case (ph_q)
              2'd0: sda_drv_q <= ~tx_q[8];
              2'd1: scl_drv_q <= 1'b0;
              2'd2: begin
                rx_q <= {rx_q[7:0], sda_s};
                if (arb) begin
                  sda_drv_q <= 1'b0;
                  scl_drv_q <= 1'b0;
                  owns_q <= 1'b0;
                  mrx_q <= 1'b0;
                  flag_q <= 1'b1;
                  status_q <= `ST_ARB_LOST;
                  state_q <= S_IDLE;
                end
              end
              default: begin
                scl_drv_q <= 1'b1;
                tx_q <= {tx_q[7:0], 1'b1};
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'd8) begin
                  sda_drv_q <= 1'b0;
                  flag_q <= 1'b1;
                  state_q <= S_IDLE;
                  if (kind_q == K_ADDR) begin
                    mrx_q <= data_q[0];
                    if (data_q[0]) begin
                      status_q <= nack_in ? `ST_AR_NACK : `ST_AR_ACK;
                    end else begin
                      status_q <= nack_in ? `ST_AW_NACK : `ST_AW_ACK;
                    end
                  end else if (kind_q == K_TX) begin
                    status_q <= nack_in ? `ST_DT_NACK : `ST_DT_ACK;
                  end else begin
                    data_q <= rx_q[8:1];
                    status_q <= tx_q[8] ? `ST_DR_NACK : `ST_DR_ACK;
                  end
                end
              end
            endcase
          end
        end
        S_STOP: begin
          if (step) begin
            ph_q <= ph_q + 2'd1;
            case (ph_q)
              2'd0: sda_drv_q <= 1'b1;
              2'd1: scl_drv_q <= 1'b0;
              2'd2: sda_drv_q <= 1'b0;
              default: begin
                stop_q <= 1'b0;
                owns_q <= 1'b0;
                mrx_q <= 1'b0;
                status_q <= `ST_NONE;
                state_q <= start_q ? S_WAIT_FREE : S_IDLE;
              end
            endcase
          end
        end
        default: state_q <= S_IDLE;
      endcase
      // Disabling the interface drops the bus at once.
      if (!en_q) begin
        state_q <= S_IDLE;
        scl_drv_q <= 1'b0;
        sda_drv_q <= 1'b0;
        owns_q <= 1'b0;
        mrx_q <= 1'b0;
      end
    end
  end

endmodule // two_wire_master_receiver

`default_nettype wire

// >>> common/two_wire_map.vh
// Register map, field positions, status codes and timing of the two-wire master receiver.
`ifndef TWO_WIRE_MAP_VH
`define TWO_WIRE_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CONTROL 5'h00
`define OFF_STATUS 5'h04
`define OFF_DATA 5'h08
`define OFF_RATE 5'h0c
`define OFF_MODE 5'h10

// ****************************************
// Control field positions
// ****************************************
`define CTL_FLAG 7
`define CTL_ACK 6
`define CTL_START 5
`define CTL_STOP 4
`define CTL_WC 3
`define CTL_EN 2
`define CTL_IE 0

// ****************************************
// Reset values
// ****************************************
`define DATA_RST 8'hff
`define STATUS_RST 8'hf8

// ****************************************
// Status codes
// ****************************************
`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_AW_ACK 8'h18
`define ST_AW_NACK 8'h20
`define ST_DT_ACK 8'h28
`define ST_DT_NACK 8'h30
`define ST_ARB_LOST 8'h38
`define ST_AR_ACK 8'h40
`define ST_AR_NACK 8'h48
`define ST_DR_ACK 8'h50
`define ST_DR_NACK 8'h58
`define ST_NONE 8'hf8

// ****************************************
// Bus responses
// ****************************************
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 4
`define BIT_PERIOD_NS 10000
`define QUARTER_CYCLES ((`BIT_PERIOD_NS / 4) / `CLK_PERIOD_NS)

`endif

// >>> src/line_monitor.v
// Two-wire line synchroniser and bus busy detector.
`timescale 1ns/1ns
`default_nettype none

module line_monitor (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Raw lines
  input wire i_scl,
  input wire i_sda,
  // Synchronised lines and bus state
  output reg o_scl_s,
  output reg o_sda_s,
  output reg o_busy
);

  reg scl_m_q;
  reg sda_m_q;
  reg sda_p_q;

  // ****************************************
  // Two-stage synchronisers and START or STOP detection
  // ****************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      scl_m_q <= 1'b1;
      sda_m_q <= 1'b1;
      o_scl_s <= 1'b1;
      o_sda_s <= 1'b1;
      sda_p_q <= 1'b1;
      o_busy <= 1'b0;
    end else begin
      scl_m_q <= i_scl;
      sda_m_q <= i_sda;
      o_scl_s <= scl_m_q;
      o_sda_s <= sda_m_q;
      sda_p_q <= o_sda_s;
      if (o_scl_s && sda_p_q && !o_sda_s) begin
        o_busy <= 1'b1;
      end else if (o_scl_s && !sda_p_q && o_sda_s) begin
        o_busy <= 1'b0;
      end
    end
  end

endmodule // line_monitor

`default_nettype wire

// >>> sim/two_wire_master_receiver_props.sv
// Checker for the register bus and the bus lines of the master receiver.
`timescale 1ns/1ns
`default_nettype none

module two_wire_master_receiver_props (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  // Bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_scl,
  input wire logic o_sda,
  input wire logic o_scl_oe_n,
  input wire logic o_sda_oe_n
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_wr_resp;
    !o_awready ##1 o_bvalid;
  endsequence
  sequence s_start;
    o_scl_oe_n && i_scl && $fell(o_sda_oe_n);
  endsequence
  chk_wr_resp: assert property (s_wr_take |=> s_wr_resp)
    else $error("write response not on time");
  chk_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  chk_rd_resp: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read response not on time");
  chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  chk_lines_zero: assert property (!o_scl && !o_sda)
    else $error("line driven high");
  chk_start_free: assert property (s_start |-> $past(i_sda) ##1 !o_sda_oe_n [*3])
    else $error("start on busy line");
  chk_stop_free: assert property (
    o_scl_oe_n && i_scl && $rose(o_sda_oe_n) |=> o_scl_oe_n [*2])
    else $error("clock pulled after stop");
  chk_scl_held: assert property ($fell(o_scl_oe_n) |=> !o_scl_oe_n)
    else $error("clock low too short");
  chk_reset_idle: assert property ($fell(i_rst) |-> o_scl_oe_n && o_sda_oe_n && o_awready
    && o_arready && !o_bvalid && !o_rvalid)
    else $error("not idle after reset");
endmodule // two_wire_master_receiver_props

bind two_wire_master_receiver two_wire_master_receiver_props i_props (.i_clk, .i_rst,
  .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
  .o_arready, .o_rvalid, .i_rready, .o_rdata, .i_scl, .i_sda, .o_scl, .o_sda, .o_scl_oe_n,
  .o_sda_oe_n);

`default_nettype wire

// >>> sim/two_wire_slave_model.sv
// Slave transmitter on the two-wire bus, with optional clock stretching.
`timescale 1ns/1ns
`default_nettype none

module two_wire_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] BASE = 8'h96
) (
  // Master line enables
  input wire logic i_scl_oe_n,
  input wire logic i_sda_oe_n,
  input wire logic i_slow,
  // Line levels
  output logic o_scl,
  output logic o_sda
);
  // ****************************************
  // Protocol
  // ****************************************
  logic hold = 0, rel = 1, act = 0, first, snd, mack;
  logic [7:0] sh, txb;
  int cnt, idx;
  assign o_scl = i_scl_oe_n & ~hold;
  assign o_sda = i_sda_oe_n & rel;
  always @(negedge o_sda) if (o_scl) begin
    act = 1;
    // The START's own clock fall brings the count to zero.
    cnt = -1;
    first = 1;
    snd = 0;
    idx = 0;
    rel = 1;
  end
  always @(posedge o_sda) if (o_scl) begin
    act = 0;
    rel = 1;
  end
  always @(posedge o_scl) if (act) begin
    if (cnt < 8) sh = {sh[6:0], o_sda};
    else mack = o_sda;
  end
  always @(negedge o_scl) if (act) begin
    cnt = cnt + 1;
    if (cnt == 8) rel = first ? (sh[7:1] != ADDR) : 1'b1;
    else if (cnt == 9) begin
      cnt = 0;
      if (first) snd = sh[0] && (sh[7:1] == ADDR);
      else if (snd) begin
        snd = !mack;
        idx++;
      end
      first = 0;
      txb = BASE + idx[7:0];
      rel = snd ? txb[7] : 1'b1;
    end else if (snd) rel = txb[7-cnt];
    if (i_slow) begin
      hold = 1;
      #200 hold = 0;
    end
  end
endmodule // two_wire_slave_model

`default_nettype wire

// >>> sim/tb_two_wire_master_receiver.sv
// Testbench for the two-wire master receiver.
`timescale 1ns/1ns
`default_nettype none
`include "two_wire_map.vh"

module tb_two_wire_master_receiver;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic i_clk = 0, i_rst = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, slow = 0;
  logic [4:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, v;
  logic [1:0] r;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_scl, o_sda;
  wire o_scl_oe_n, o_sda_oe_n, scl, sda;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  int errors = 0, n_checks = 0, cyc = 0;
  always #2 i_clk = ~i_clk;
  two_wire_master_receiver i_two_wire_master_receiver (.i_clk, .i_rst, .i_awvalid,
    .o_awready, .i_awaddr, .i_awprot(3'h0), .i_wvalid, .o_wready, .i_wdata, .i_wstrb(4'hf),
    .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .i_arprot(3'h0),
    .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_scl(scl), .o_scl, .o_scl_oe_n,
    .i_sda(sda), .o_sda, .o_sda_oe_n);
  two_wire_slave_model i_two_wire_slave_model (.i_scl_oe_n(o_scl_oe_n),
    .i_sda_oe_n(o_sda_oe_n), .i_slow(slow), .o_scl(scl), .o_sda(sda));
  // ****************************************
  // Tasks
  // ****************************************
  task chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
      i_bready <= o_bvalid;
    end while (!(o_bvalid === 1'b1 && i_bready));
    i_bready <= 0;
    r = o_bresp;
  endtask
  task rd(input logic [4:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 0;
      i_rready <= o_rvalid;
    end while (!(o_rvalid === 1'b1 && i_rready));
    v = o_rdata;
    r = o_rresp;
  endtask
  task go(input logic [7:0] c, e);
    wr(`OFF_CONTROL, {24'h0, c});
    do rd(`OFF_CONTROL);
    while (v[7] !== 1'b1 && !(c[4] && !c[5] && v[4] === 1'b0));
    rd(`OFF_STATUS);
    chk("status", v & 32'hf8, {24'h0, e});
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      end_sim;
    end
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 0;
    rd(`OFF_CONTROL);
    chk("control", v, 32'h0);
    rd(`OFF_STATUS);
    chk("status", v, {24'h0, `STATUS_RST});
    rd(5'h14);
    chk("rresp", r, `RESP_SLVERR);
    wr(`OFF_DATA, 32'h55);
    rd(`OFF_CONTROL);
    chk("collision", v[3], 1);
    rd(`OFF_DATA);
    chk("data", v, {24'h0, `DATA_RST});
    wr(`OFF_RATE, 32'h5);
    chk("bresp", r, `RESP_OKAY);
    wr(5'h14, 32'h0);
    chk("bresp unmapped", r, `RESP_SLVERR);
    wr(`OFF_CONTROL, 32'h4);
    go(8'ha4, `ST_START);
    chk("scl held", o_scl_oe_n, 0);
    wr(`OFF_DATA, {24'h0, 7'h2a, 1'b1});
    go(8'h84, `ST_AR_ACK);
    rd(`OFF_MODE);
    chk("receive mode", v[1], 1);
    go(8'hc4, `ST_DR_ACK);
    rd(`OFF_DATA);
    chk("byte0", v, 32'h96);
    slow <= 1;
    go(8'h84, `ST_DR_NACK);
    rd(`OFF_DATA);
    chk("byte1", v, 32'h97);
    go(8'ha4, `ST_RSTART);
    rd(`OFF_MODE);
    chk("owns bus", v[2], 1);
    wr(`OFF_DATA, {24'h0, 7'h2b, 1'b1});
    go(8'h84, `ST_AR_NACK);
    go(8'hb4, `ST_START);
    wr(`OFF_DATA, {24'h0, 7'h2b, 1'b1});
    go(8'h84, `ST_AR_NACK);
    go(8'ha4, `ST_RSTART);
    wr(`OFF_DATA, {24'h0, 7'h2a, 1'b1});
    go(8'h84, `ST_AR_ACK);
    go(8'h84, `ST_DR_NACK);
    rd(`OFF_DATA);
    chk("byte0 again", v, 32'h96);
    go(8'h94, `ST_NONE);
    rd(`OFF_CONTROL);
    chk("stop bit", v[4], 0);
    chk("scl free", o_scl_oe_n, 1);
    end_sim;
  end
endmodule // tb_two_wire_master_receiver

`default_nettype wire
